// file: rtl/sdram_core.sv
// Synchronous DRAM device: command decode, banks, bursts and APB view
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// - Burst length 1, 2, 4, 8 or page
// - Read data after CAS latency 2 or 3
// - Sequential or interleaved burst column order
// - Four banks, 4096 rows, 256 columns, 16 bits
// - Activate takes bank and full row address
// - Read/write takes low column bits, bit ten autoprecharge
// - Precharge scope bit selects all or one bank
// - Load mode captures address as mode
// - Auto precharge closes row after burst
// - Burst stop, or precharge of the burst's bank or of all banks, ends burst
// - Burst reads with single-location writes mode
// - New column command accepted every cycle
// - All inputs captured on rising edge
// - Burst columns generated internally
// - Precharge one bank while others access
// - Separate low and high byte masks
// - Mask tri-states reads, drops write bytes
// - Chip select high ignores commands
// - Clock gate low freezes all state
module sdram_core
  import sdram_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int ROWS = 4096,
  parameter int COLS = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clock_gate,
  input wire cmd_pins_t cmd_pins,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out_q,
  output logic [BYTES-1:0] dq_oe_n_q,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q
);

  localparam int DEPTH = BANKS * ROWS * COLS;
  localparam int IDX_W = $clog2(DEPTH);

  // Column of a burst beat; mask spans the wrap window of the length
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
    input logic [MODE_W-1:0] mode);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] sum;
    m = 8'h00;
    unique case (mode[MODE_BL_LSB +: MODE_BL_W])
      BL_2: m = 8'h01;
      BL_4: m = 8'h03;
      BL_8: m = 8'h07;
      BL_PAGE: m = 8'hff;
      default: m = 8'h00;
    endcase
    sum = start + idx;
    // Full page has no interleaved form, so it always counts up
    if (mode[MODE_BT_BIT] && m != 8'hff)
      return (start & ~m) | ((start ^ idx) & m);
    return (start & ~m) | (sum & m);
  endfunction : burst_col

  // Last beat index for a burst kind; page bursts never end by count
  function automatic logic [COL_W-1:0] burst_last(
    input logic [MODE_W-1:0] mode, input logic wr);
    if (wr && mode[MODE_WB_BIT]) return 8'h00;
    unique case (mode[MODE_BL_LSB +: MODE_BL_W])
      BL_2: return 8'h01;
      BL_4: return 8'h03;
      BL_8: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction : burst_last

  function automatic logic is_page(input logic [MODE_W-1:0] mode,
                                   input logic wr);
    return mode[MODE_BL_LSB +: MODE_BL_W] == BL_PAGE &&
           !(wr && mode[MODE_WB_BIT]);
  endfunction : is_page

  cmd_t cmd;
  logic [BANK_W-1:0] cmd_bank;
  logic [ROW_W-1:0] cmd_addr;
  logic [BYTES-1:0] byte_mask;
  logic [MODE_W-1:0] mode_q;
  logic [BANKS-1:0] row_open_q;
  logic [ROW_W-1:0] row_q [BANKS];
  logic burst_act_q;
  logic burst_wr_q;
  logic burst_ap_q;
  logic [BANK_W-1:0] burst_bank_q;
  logic [COL_W-1:0] start_q;
  logic [COL_W-1:0] idx_q;
  logic new_rw;
  logic stop;
  logic beat_valid;
  logic beat_wr;
  logic beat_ap;
  logic beat_last;
  logic [BANK_W-1:0] beat_bank;
  logic [COL_W-1:0] beat_col;
  logic [IDX_W-1:0] beat_idx;
  logic [DATA_W-1:0] mem [DEPTH];
  logic s1_valid_q;
  logic s2_valid_q;
  logic [DATA_W-1:0] s1_data_q;
  logic [DATA_W-1:0] s2_data_q;
  logic apb_access;
  logic apb_wr_mode;
  logic [7:0] apb_ofs;
  logic [31:0] status_word;

  // Pins come from logic on the same clock, so no synchroniser here
  assign cmd = decode_cmd(cmd_pins);
  assign cmd_bank = cmd_pins.bank_select_inputs;
  assign cmd_addr = cmd_pins.row_column_address_inputs;
  assign byte_mask = {high_byte_mask, low_byte_mask};

  // Read or write only lands in a bank whose row is open
  assign new_rw = (cmd == CMD_READ || cmd == CMD_WRITE) &&
                  row_open_q[cmd_bank];
  // Precharge of another bank leaves the running burst alone
  assign stop = burst_act_q && (cmd == CMD_BURST_STOP ||
                (cmd == CMD_PRECHARGE &&
                 (cmd_addr[PRECHARGE_SCOPE_BIT] ||
                  cmd_bank == burst_bank_q)));

  // Current beat: a fresh command wins over the burst in flight
  always_comb begin
    beat_valid = 1'b0;
    beat_wr = burst_wr_q;
    beat_ap = burst_ap_q;
    beat_bank = burst_bank_q;
    beat_col = burst_col(start_q, idx_q, mode_q);
    beat_last = !is_page(mode_q, burst_wr_q) &&
                idx_q == burst_last(mode_q, burst_wr_q);
    if (new_rw) begin
      beat_valid = 1'b1;
      beat_wr = cmd == CMD_WRITE;
      beat_ap = cmd_addr[PRECHARGE_SCOPE_BIT];
      beat_bank = cmd_bank;
      beat_col = cmd_addr[COL_W-1:0];
      beat_last = !is_page(mode_q, beat_wr) &&
                  burst_last(mode_q, beat_wr) == 8'h00;
    end else if (burst_act_q && !stop) begin
      beat_valid = 1'b1;
    end
  end

  // Flat array index: bank, open row, column
  assign beat_idx = IDX_W'((int'(beat_bank) * ROWS +
                            int'(row_q[beat_bank])) * COLS +
                           int'(beat_col));

  // Mode register; a pin load wins over an APB write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
    end else if (clock_gate) begin
      if (cmd == CMD_LOAD_MODE) begin
        mode_q <= cmd_addr;
      end else if (apb_wr_mode) begin
        mode_q <= pwdata[MODE_W-1:0];
      end
    end
  end

  // Bank bookkeeping: one open row per bank, each bank independent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_open_q <= '0;
      for (int b = 0; b < BANKS; b++) row_q[b] <= '0;
    end else if (clock_gate) begin
      if (beat_valid && beat_last && beat_ap) begin
        row_open_q[beat_bank] <= 1'b0;
      end
      if (cmd == CMD_PRECHARGE) begin
        if (cmd_addr[PRECHARGE_SCOPE_BIT]) begin
          row_open_q <= '0;
        end else begin
          row_open_q[cmd_bank] <= 1'b0;
        end
      end
      if (cmd == CMD_ACTIVE) begin
        row_open_q[cmd_bank] <= 1'b1;
        row_q[cmd_bank] <= cmd_addr;
      end
    end
  end

  // Burst sequencer: counts beats until length, stop or a new command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_ap_q <= 1'b0;
      burst_bank_q <= '0;
      start_q <= '0;
      idx_q <= '0;
    end else if (clock_gate) begin
      if (new_rw) begin
        burst_act_q <= !beat_last;
        burst_wr_q <= beat_wr;
        burst_ap_q <= beat_ap;
        burst_bank_q <= cmd_bank;
        start_q <= cmd_addr[COL_W-1:0];
        idx_q <= 8'h01;
      end else if (stop) begin
        burst_act_q <= 1'b0;
      end else if (burst_act_q) begin
        burst_act_q <= !beat_last;
        idx_q <= idx_q + 8'h01;
      end
    end
  end

  // Storage and read fetch; masked bytes keep their old contents
  always_ff @(posedge pclk) begin
    if (clock_gate) begin
      s1_data_q <= mem[beat_idx];
      s2_data_q <= s1_data_q;
      for (int b = 0; b < BYTES; b++) begin
        if (beat_valid && beat_wr && !byte_mask[b]) begin
          mem[beat_idx][b*8 +: 8] <= dq_in[b*8 +: 8];
        end
      end
    end
  end

  // Read latency pipe: beat at edge 0 is on the pins for edge CL
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid_q <= 1'b0;
      s2_valid_q <= 1'b0;
      dq_out_q <= '0;
      dq_oe_n_q <= '1;
    end else if (clock_gate) begin
      s1_valid_q <= beat_valid && !beat_wr;
      s2_valid_q <= s1_valid_q;
      if (mode_q[MODE_CL_LSB +: MODE_CL_W] == CL_3) begin
        dq_out_q <= s2_data_q;
        dq_oe_n_q <= {BYTES{!s2_valid_q}} | byte_mask;
      end else begin
        dq_out_q <= s1_data_q;
        dq_oe_n_q <= {BYTES{!s1_valid_q}} | byte_mask;
      end
    end
  end

  // APB slave: one wait state, answer registered; gated clock stalls it
  assign apb_access = psel && penable && !pready_q;
  assign apb_ofs = paddr[7:0];
  // Write lands at the completing edge, while pready_q is seen high
  assign apb_wr_mode = psel && penable && pready_q && pwrite &&
                       paddr[31:8] == 24'h000000 && apb_ofs == MODE_OFS;
  always_comb begin
    status_word = '0;
    status_word[BANKS-1:0] = row_open_q;
    status_word[STAT_BURST_BIT] = burst_act_q;
    status_word[STAT_WRITE_BIT] = burst_wr_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (clock_gate) begin
      pready_q <= apb_access;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (apb_access) begin
        if (paddr[31:8] != 24'h000000 ||
            (apb_ofs != MODE_OFS && apb_ofs != STATUS_OFS) ||
            (apb_ofs == STATUS_OFS && pwrite)) begin
          pslverr_q <= 1'b1; // Unmapped or read-only target
        end else if (!pwrite) begin
          prdata_q <= (apb_ofs == MODE_OFS) ?
                      {20'h00000, mode_q} : status_word;
        end
      end
    end
  end

  // Checks on the device behaviour
  logic quiet;
  assign quiet = cmd == CMD_NOP || cmd == CMD_DESELECT;
  a_activate_row: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && cmd == CMD_ACTIVE |=>
      row_open_q[$past(cmd_bank)] && row_q[$past(cmd_bank)] ==
      $past(cmd_addr))
    else $error("activate did not open the addressed row");
  a_precharge_all: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && cmd == CMD_PRECHARGE && cmd_addr[PRECHARGE_SCOPE_BIT]
      |=> row_open_q == '0)
    else $error("precharge all left a bank open");
  a_latency_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && new_rw && cmd == CMD_READ &&
    mode_q[MODE_CL_LSB +: MODE_CL_W] == CL_2
      ##1 (clock_gate && byte_mask == '0) |=> dq_oe_n_q == '0)
    else $error("read data missing at latency two");
  a_latency_three: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && new_rw && cmd == CMD_READ &&
    mode_q[MODE_CL_LSB +: MODE_CL_W] == CL_3 ##1 clock_gate
      ##1 (clock_gate && byte_mask == '0) |=> dq_oe_n_q == '0)
    else $error("read data missing at latency three");
  a_deselect_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && cmd_pins.chip_select_n && !burst_act_q && !apb_wr_mode
      |=> $stable(row_open_q) && $stable(mode_q))
    else $error("state changed while deselected");
  a_gate_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clock_gate |=> $stable(row_open_q) && $stable(idx_q) &&
      $stable(dq_out_q) && $stable(pready_q))
    else $error("state moved with clock gate low");
  a_stop_burst: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && burst_act_q && cmd == CMD_BURST_STOP |=> !burst_act_q)
    else $error("burst stop did not end the burst");
  a_auto_close: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && beat_valid && beat_last && beat_ap &&
    !(cmd == CMD_ACTIVE) |=> !row_open_q[$past(beat_bank)])
    else $error("auto precharge left the row open");
  a_mode_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && cmd == CMD_LOAD_MODE |=> mode_q == $past(cmd_addr))
    else $error("mode register not loaded from address");
  a_four_beats: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && new_rw && cmd == CMD_READ &&
    mode_q[MODE_BL_LSB +: MODE_BL_W] == BL_4 ##1
      (clock_gate && quiet && burst_act_q)[*3] |=> !burst_act_q)
    else $error("burst of four ran a wrong length");
  a_single_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && new_rw && cmd == CMD_WRITE && mode_q[MODE_WB_BIT]
      |=> !burst_act_q)
    else $error("single write mode ran a write burst");
  a_new_column: assert property (
    @(posedge pclk) disable iff (!presetn)
    clock_gate && new_rw |=> start_q == $past(cmd_addr[COL_W-1:0]) &&
      idx_q == 8'h01)
    else $error("new column command not taken");
  c_read_cl3: cover property (@(posedge pclk) disable iff (!presetn)
    new_rw && cmd == CMD_READ && mode_q[MODE_CL_LSB +: MODE_CL_W] == CL_3);
  c_write_burst: cover property (@(posedge pclk) disable iff (!presetn)
    burst_act_q && burst_wr_q && beat_last);
  c_auto_pre: cover property (@(posedge pclk) disable iff (!presetn)
    beat_valid && beat_last && beat_ap);
  c_stop: cover property (@(posedge pclk) disable iff (!presetn)
    stop && clock_gate);
endmodule : sdram_core

// file: rtl/sdram_pkg.sv
// Shared constants, types and decode helpers for the synchronous DRAM core
package sdram_pkg;

  // Array geometry: four banks, 4096 rows, 256 columns of 16 bits
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTES = 2;

  // Address bit that asks for auto precharge or all-bank precharge
  localparam int PRECHARGE_SCOPE_BIT = 10;

  // Mode register layout
  localparam int MODE_W = 12;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_W = 3;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_CL_W = 3;
  localparam int MODE_WB_BIT = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;

  // Burst length codes and CAS latency codes
  localparam logic [MODE_BL_W-1:0] BL_1 = 3'h0;
  localparam logic [MODE_BL_W-1:0] BL_2 = 3'h1;
  localparam logic [MODE_BL_W-1:0] BL_4 = 3'h2;
  localparam logic [MODE_BL_W-1:0] BL_8 = 3'h3;
  localparam logic [MODE_BL_W-1:0] BL_PAGE = 3'h7;
  localparam logic [MODE_CL_W-1:0] CL_2 = 3'h2;
  localparam logic [MODE_CL_W-1:0] CL_3 = 3'h3;

  // APB register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int STAT_BURST_BIT = 4;
  localparam int STAT_WRITE_BIT = 5;

  // Command pins sampled together on each rising edge
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
    logic [BANK_W-1:0] bank_select_inputs;
    logic [ROW_W-1:0] row_column_address_inputs;
  } cmd_pins_t;

  typedef enum {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_BURST_STOP, CMD_LOAD_MODE, CMD_REFRESH
  } cmd_t;

  // Strobe triple to command
  function automatic cmd_t decode_cmd(input cmd_pins_t p);
    logic [2:0] s;
    s = {p.row_strobe_n, p.col_strobe_n, p.write_enable_n};
    if (p.chip_select_n) return CMD_DESELECT;
    unique case (s)
      3'h3: return CMD_ACTIVE;
      3'h5: return CMD_READ;
      3'h4: return CMD_WRITE;
      3'h2: return CMD_PRECHARGE;
      3'h6: return CMD_BURST_STOP;
      3'h0: return CMD_LOAD_MODE;
      3'h1: return CMD_REFRESH;
      3'h7: return CMD_NOP;
    endcase
  endfunction : decode_cmd

endpackage : sdram_pkg

// file: sim/sdram_ctrl_model.sv
// Memory controller model driving command, mask and write data pins
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_pkg::*;
(
  output cmd_pins_t cmd_pins,
  output logic low_byte_mask,
  output logic high_byte_mask,
  output logic [DATA_W-1:0] dq_in,
  input wire logic pclk
);
  // Deselected at time zero so nothing can be taken as a command
  initial begin
    cmd_pins = '1;
    low_byte_mask = 1'b0;
    high_byte_mask = 1'b0;
    dq_in = '0;
  end

  // One command per edge, launched just after a rising edge
  task automatic send(input logic [3:0] s, input logic [1:0] b,
      input logic [11:0] a, input logic [15:0] d, input logic [1:0] m);
    @(posedge pclk);
    cmd_pins <= {s, b, a};
    dq_in <= d;
    {high_byte_mask, low_byte_mask} <= m;
  endtask : send

  // Idle: deselected, address and data inverted so stale values never
  // pass for valid ones; masks held because read masks act one edge late
  task automatic idle();
    @(posedge pclk);
    cmd_pins <= {4'hf, ~cmd_pins[13:0]};
    dq_in <= ~dq_in;
  endtask : idle
endmodule : sdram_ctrl_model

// file: sim/test_sdram_command_interface.sv
// Self-checking bench for the synchronous DRAM core
`timescale 1ns/1ps
module test_sdram_command_interface
  import sdram_pkg::*;
;
  localparam logic [3:0] S_ACT = 4'h3, S_RD = 4'h5, S_WR = 4'h4;
  localparam logic [3:0] S_PRE = 4'h2, S_BST = 4'h6, S_LMR = 4'h0;
  localparam logic [3:0] S_REF = 4'h1, S_NOP = 4'h7;
  localparam logic [11:0] CFG [9] = '{12'h020, 12'h031, 12'h02a, 12'h032,
    12'h232, 12'h03b, 12'h023, 12'h027, 12'h02f};
  logic pclk, presetn, clock_gate, psel, penable, pwrite, err, il, sw;
  logic [31:0] paddr, pwdata, prdata_q, rd, seed;
  logic pready_q, pslverr_q, low_byte_mask, high_byte_mask;
  logic [DATA_W-1:0] dq_in, dq_out_q, d;
  logic [BYTES-1:0] dq_oe_n_q, rmask, b;
  logic [11:0] r, a, x;
  cmd_pins_t cmd_pins;
  logic [15:0] mem [int];
  logic [15:0] obs_dq [0:15];
  logic [1:0] obs_oe [0:15];
  int n_fail, compares, bl, cl, n;

  // Row count shrunk: only the low row bits are exercised
  sdram_core #(.ROWS(16)) sdram_core_inst (.pclk(pclk), .presetn(presetn),
    .clock_gate(clock_gate), .cmd_pins(cmd_pins),
    .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
    .dq_in(dq_in), .dq_out_q(dq_out_q), .dq_oe_n_q(dq_oe_n_q),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q));
  sdram_ctrl_model ctrl (.cmd_pins(cmd_pins), .low_byte_mask(low_byte_mask),
    .high_byte_mask(high_byte_mask), .dq_in(dq_in), .pclk(pclk));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Burst column: wraps inside the aligned block; page always counts up
  function automatic logic [7:0] bcol(input logic [7:0] c, input int i);
    logic [7:0] m;
    m = 8'(bl - 1);
    return (c & ~m) | (((il && bl != 256) ? (c ^ 8'(i)) : (c + 8'(i))) & m);
  endfunction : bcol

  function automatic int key(input logic [1:0] bk, input logic [11:0] rw,
      input logic [7:0] c);
    return int'({bk, rw, c});
  endfunction : key

  task automatic close_out();
    $display("mismatches %0d, compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string what);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk

  // Setup, then access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [31:0] ad,
      input logic [31:0] wd);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready_q === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      close_out();
    end
    rd = prdata_q;
    err = pslverr_q;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic stat(input logic [3:0] e);
    apb(1'b0, {24'h0, STATUS_OFS}, 32'h0);
    chk(rd[3:0], e, "open banks");
  endtask : stat

  task automatic setm(input logic [11:0] v);
    bl = (v[2:0] == BL_PAGE) ? 256 : (1 << v[2:0]);
    il = v[3];
    cl = (v[6:4] == CL_3) ? 3 : 2;
    sw = v[9];
  endtask : setm

  task automatic lmr(input logic [11:0] v);
    ctrl.send(S_LMR, 2'h0, v, 16'h0, 2'h0);
    ctrl.idle();
    setm(v);
    apb(1'b0, {24'h0, MODE_OFS}, 32'h0);
    chk(rd, {20'h0, v}, "mode");
  endtask : lmr

  // Reference keeps unknown bytes as x so they are never compared
  task automatic upd(input int k, input logic [15:0] dv, input logic [1:0] m);
    logic [15:0] o;
    o = mem.exists(k) ? mem[k] : 16'hxxxx;
    if (!m[0]) o[7:0] = dv[7:0];
    if (!m[1]) o[15:8] = dv[15:8];
    mem[k] = o;
  endtask : upd

  // Write burst; a trailing stop ends page bursts and is harmless else
  task automatic wrb(input int nb, input logic [1:0] m);
    for (int k = 0; k < nb; k++) begin
      d = 16'(rnd());
      ctrl.send(k == 0 ? S_WR : S_NOP, b, a, d, m);
      if (k == 0 || !sw) upd(key(b, r, bcol(a[7:0], k)), d, m);
    end
    ctrl.send(S_BST, b, a, 16'h0, m);
  endtask : wrb

  // Read, optionally with one command taken s edges after the read
  task automatic rdb(input logic [11:0] ra, input int nb, input int s,
      input logic [17:0] p);
    logic [15:0] e;
    int k;
    ctrl.send(S_RD, b, ra, 16'h0, rmask);
    for (int i = 1; i <= nb + cl + 1; i++) begin
      if (i == s) ctrl.send(p[17:14], p[13:12], p[11:0], 16'h0, rmask);
      else ctrl.idle();
      @(negedge pclk);
      obs_dq[i] = dq_out_q;
      obs_oe[i] = dq_oe_n_q;
    end
    for (int j = 0; j < nb; j++) begin
      k = key(b, r, bcol(ra[7:0], j));
      e = mem.exists(k) ? mem[k] : 16'hxxxx;
      chk(obs_oe[j + cl], rmask, "byte enables");
      for (int y = 0; y < 2; y++)
        if (!rmask[y] && !$isunknown(e[8*y+:8]))
          chk(obs_dq[j + cl][8*y+:8], e[8*y+:8], "beat");
    end
    chk(obs_oe[nb + cl], 2'h3, "burst end");
  endtask : rdb

  initial begin
    seed = 32'h000009dc;
    {n_fail, compares} = '0;
    {presetn, psel, penable, pwrite} = 4'h0;
    clock_gate = 1'b1;
    {paddr, pwdata} = '0;
    rmask = 2'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(dq_oe_n_q, 2'h3, "reset enables");
    apb(1'b0, {24'h0, MODE_OFS}, 32'h0);
    chk(rd, {20'h0, MODE_RESET}, "reset mode");
    stat(4'h0);
    apb(1'b0, 32'h00000008, 32'h0);
    chk(err, 1'b1, "unmapped");
    apb(1'b1, {24'h0, STATUS_OFS}, 32'h0);
    chk(err, 1'b1, "status write");
    ctrl.send(S_REF, 2'h0, 12'h0, 16'h0, 2'h0);
    // Every length, both orders and latencies; single-write reuses cells
    foreach (CFG[i]) begin
      lmr(CFG[i]);
      x = 12'(rnd());
      if (!CFG[i][9]) begin
        b = x[1:0];
        r = 12'(x[5:2]);
        a = {x[11], 1'b0, x[7:6], 8'(rnd())};
      end
      ctrl.send(S_PRE, 2'h0, 12'h400, 16'h0, 2'h0);
      ctrl.send(S_ACT, b, r, 16'h0, 2'h0);
      n = (bl == 256) ? 8 : bl;
      wrb(n, 2'(rnd() & (rnd() >> 2)));
      rmask = 2'(rnd());
      rdb(a, n, n, {S_BST, b, a});
    end
    rdb(a, 3, 3, {S_PRE, b, 12'h000});
    stat(4'h0);
    apb(1'b1, {24'h0, MODE_OFS}, 32'h00000222);
    setm(12'h222);
    apb(1'b0, {24'h0, MODE_OFS}, 32'h0);
    chk(rd, 32'h00000222, "mode by bus");
    for (int k = 0; k < 4; k++)
      ctrl.send(S_ACT, 2'(k), 12'h1, 16'h0, 2'h0);
    // Deselect at once so the last activate is not taken again
    ctrl.idle();
    stat(4'hf);
    {b, r, a} = {2'h0, 12'h1, 4'h0, 8'(rnd()) & 8'hfc};
    for (int k = 0; k < 4; k++) begin
      d = 16'(rnd());
      ctrl.send(S_WR, b, a | 12'(k), d, 2'h0);
      upd(key(b, r, a[7:0] | 8'(k)), d, 2'h0);
    end
    rmask = 2'h0;
    rdb(a, 4, 1, {S_PRE, 2'h1, 12'h000});
    stat(4'hd);
    ctrl.send(4'ha, 2'h0, 12'h400, 16'h0, 2'h0);
    stat(4'hd);
    // Gate low across the edge that carries a precharge-all
    @(posedge pclk);
    clock_gate <= 1'b0;
    ctrl.send(S_PRE, 2'h0, 12'h400, 16'h0, 2'h0);
    ctrl.idle();
    clock_gate <= 1'b1;
    stat(4'hd);
    ctrl.send(S_ACT, 2'h1, 12'h2, 16'h0, 2'h0);
    rdb(a | 12'h400, 4, 0, 18'h0);
    stat(4'he);
    close_out();
  end
endmodule : test_sdram_command_interface
